/* File: hw/inband_loop_code_unit.sv */
// Loop-code unit: register slave, pin sync, transmit code, auto loopback.
`timescale 1ns/1ps
// *******************************************************************
// Operation
// - Report receive level code in bits 7:4.
// - Info bits 3 and 2 unassigned.
// - Auto loopback sets after 5 s up-code.
// - Auto loopback clears after 5 s down-code.
// - Auto loopback status low when disabled.
// - One-second flag latched, cleared by read.
// - Patterns of 1 to 8 or 16 bits.
// - Transmit code only while enable set.
// - Separate up and down detectors.
// - Detect despite one-percent bit errors.
// - About 48 ms integration sets status bits.
// - Length control fields at 7:6, 5:3, 2:0.
// - Transmit select gives 5, 6/3, 7, 16.
// - Receive select gives 1 to 7, 16/8.
// - First code bit is low-byte bit 7.
// - Up and down status bits are latched.
// *******************************************************************
module inband_loop_code_unit
  import lcu_pkg::*;
#(
  parameter int INTEG_BITS  = INTEG_BITS_DFLT,
  parameter int SECOND_BITS = SECOND_BITS_DFLT
) (
  // Clock and reset.
  input  logic        aclk,
  input  logic        aresetn,
  // Write address channel.
  input  logic        awvalid,
  output logic        awready,
  input  logic [7:0]  awaddr,
  // Write data channel.
  input  logic        wvalid,
  output logic        wready,
  input  logic [31:0] wdata,
  input  logic [3:0]  wstrb,
  // Write response channel.
  output logic        bvalid,
  input  logic        bready,
  output logic [1:0]  bresp,
  // Read address channel.
  input  logic        arvalid,
  output logic        arready,
  input  logic [7:0]  araddr,
  // Read data channel.
  output logic        rvalid,
  input  logic        rready,
  output logic [31:0] rdata,
  output logic [1:0]  rresp,
  // Line side pins.
  input  logic        rx_clk_pin,
  input  logic        rx_data_pin,
  input  logic        tx_clk_pin,
  input  logic        tx_data_pin,
  input  logic [3:0]  rx_level_pin,
  output logic        tx_line_data,
  output logic        remote_loopback
);
  // *****************************************************************
  // Declarations
  // *****************************************************************
  logic             awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]       bresp_q, rresp_q;
  logic [31:0]      rdata_q;
  logic [5:0]       aw_idx_q;
  logic [7:0]       wdata_q;
  logic             wstrb_q;
  logic             wr_fire, rd_take;
  logic [5:0]       rd_idx;
  logic [7:0]       rd_d;
  logic             rd_ok, wr_ok;
  len_ctrl_s        len_q;
  logic [7:0]       tx_lo_q, tx_hi_q, up_lo_q, up_hi_q, dn_lo_q, dn_hi_q;
  logic [7:0]       ctrl_q;
  logic             sec_flag_q, up_flag_q, dn_flag_q;
  logic [7:0]       sync1_q, sync2_q, sync3_q;
  logic             rx_bit_en, tx_bit_en, rx_bit, tx_data_s;
  logic [3:0]       level_s;
  logic [3:0]       tx_phase_q, tx_last;
  logic [15:0]      tx_code;
  logic             tx_line_q;
  logic [SCW-1:0]   sec_cnt_q;
  logic             sec_tick_q;
  logic             up_present, dn_present, up_drop_q, dn_drop_q;
  logic [2:0]       up_secs_q, dn_secs_q;
  logic             up_ok, dn_ok, auto_en, tx_en;
  arl_state_e       arl_state_q;

  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;
  assign tx_line_data    = tx_line_q;
  assign remote_loopback = arl_state_q;
  assign tx_en           = ctrl_q[CTRL_TXE_BIT];
  assign auto_en         = ctrl_q[CTRL_ARE_BIT];

  // *****************************************************************
  // Pin synchronisers
  // *****************************************************************
  // Two stages per pin; the third stage only serves the edge detect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
    end else begin
      sync1_q <= {rx_level_pin, tx_data_pin, tx_clk_pin, rx_data_pin,
                  rx_clk_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Bit clocks are far below aclk, so rising edges become enables.
  assign rx_bit_en = sync2_q[0] & ~sync3_q[0];
  assign rx_bit    = sync2_q[1];
  assign tx_bit_en = sync2_q[2] & ~sync3_q[2];
  assign tx_data_s = sync2_q[3];
  assign level_s   = sync2_q[7:4];

  // *****************************************************************
  // Register bus
  // *****************************************************************
  // A write runs once address and data are both held and no answer is
  // pending; ready stays low from each hand-over until the answer is taken.
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign rd_take = arvalid && arready_q;
  assign rd_idx  = araddr[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_idx_q  <= 6'h00;
      wdata_q   <= 8'h00;
      wstrb_q   <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_idx_q  <= awaddr[7:2];
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        wdata_q  <= wdata[7:0];
        wstrb_q  <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read-only registers accept a write and ignore it.
  always_comb begin
    wr_ok = (aw_idx_q >= IDX_RX_INFO && aw_idx_q <= IDX_DN_HI)
            || aw_idx_q == IDX_CTRL || aw_idx_q == IDX_STATUS;
  end

  // Writable registers; only byte lane 0 carries data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q   <= len_ctrl_s'(LEN_CTRL_RST);
      tx_lo_q <= PATTERN_RST;
      tx_hi_q <= PATTERN_RST;
      up_lo_q <= PATTERN_RST;
      up_hi_q <= PATTERN_RST;
      dn_lo_q <= PATTERN_RST;
      dn_hi_q <= PATTERN_RST;
      ctrl_q  <= CTRL_RST;
    end else if (wr_fire && wstrb_q) begin
      if (aw_idx_q == IDX_LEN_CTRL) begin
        len_q <= len_ctrl_s'(wdata_q);
      end else if (aw_idx_q == IDX_TX_LO) begin
        tx_lo_q <= wdata_q;
      end else if (aw_idx_q == IDX_TX_HI) begin
        tx_hi_q <= wdata_q;
      end else if (aw_idx_q == IDX_UP_LO) begin
        up_lo_q <= wdata_q;
      end else if (aw_idx_q == IDX_UP_HI) begin
        up_hi_q <= wdata_q;
      end else if (aw_idx_q == IDX_DN_LO) begin
        dn_lo_q <= wdata_q;
      end else if (aw_idx_q == IDX_DN_HI) begin
        dn_hi_q <= wdata_q;
      end else if (aw_idx_q == IDX_CTRL) begin
        ctrl_q <= {6'h00, wdata_q[1:0]};
      end
    end
  end

  // Read data; unassigned info bits 3:2 read as zero.
  always_comb begin
    rd_d  = 8'h00;
    rd_ok = 1'b1;
    if (rd_idx == IDX_RX_INFO) begin
      rd_d = {level_s, 2'h0, arl_state_q, sec_flag_q};
    end else if (rd_idx == IDX_LEN_CTRL) begin
      rd_d = len_q;
    end else if (rd_idx == IDX_TX_LO) begin
      rd_d = tx_lo_q;
    end else if (rd_idx == IDX_TX_HI) begin
      rd_d = tx_hi_q;
    end else if (rd_idx == IDX_UP_LO) begin
      rd_d = up_lo_q;
    end else if (rd_idx == IDX_UP_HI) begin
      rd_d = up_hi_q;
    end else if (rd_idx == IDX_DN_LO) begin
      rd_d = dn_lo_q;
    end else if (rd_idx == IDX_DN_HI) begin
      rd_d = dn_hi_q;
    end else if (rd_idx == IDX_CTRL) begin
      rd_d = ctrl_q;
    end else if (rd_idx == IDX_STATUS) begin
      rd_d = {up_flag_q, dn_flag_q, 6'h00};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // One read at a time; the address is taken with the data captured.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, rd_d};
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // *****************************************************************
  // Latched flags
  // *****************************************************************
  // A read clears at the moment it samples; a set in that cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_flag_q <= 1'b0;
      up_flag_q  <= 1'b0;
      dn_flag_q  <= 1'b0;
    end else begin
      if (sec_tick_q) begin
        sec_flag_q <= 1'b1;
      end else if (rd_take && rd_idx == IDX_RX_INFO) begin
        sec_flag_q <= 1'b0;
      end
      if (up_present) begin
        up_flag_q <= 1'b1;
      end else if (rd_take && rd_idx == IDX_STATUS) begin
        up_flag_q <= 1'b0;
      end
      if (dn_present) begin
        dn_flag_q <= 1'b1;
      end else if (rd_take && rd_idx == IDX_STATUS) begin
        dn_flag_q <= 1'b0;
      end
    end
  end

  // *****************************************************************
  // Transmit pattern
  // *****************************************************************
  // Low byte bit 7 leads; the 16/8/4/2/1 and 6/3 selects send the
  // whole configured span, so shorter codes must be replicated.
  assign tx_code = {tx_lo_q, tx_hi_q};
  always_comb begin
    if (len_q.tx_len == TX_LEN_5) begin
      tx_last = LAST_5;
    end else if (len_q.tx_len == TX_LEN_6) begin
      tx_last = LAST_6;
    end else if (len_q.tx_len == TX_LEN_7) begin
      tx_last = LAST_7;
    end else begin
      tx_last = LAST_16;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_phase_q <= 4'h0;
      tx_line_q  <= 1'b0;
    end else if (tx_bit_en) begin
      if (tx_en) begin
        tx_line_q  <= tx_code[4'hF - tx_phase_q];
        tx_phase_q <= (tx_phase_q >= tx_last) ? 4'h0 : tx_phase_q + 4'h1;
      end else begin
        tx_line_q  <= tx_data_s;
        tx_phase_q <= 4'h0;
      end
    end
  end

  // *****************************************************************
  // Code detectors
  // *****************************************************************
  repeat_code_detector #(.INTEG_BITS(INTEG_BITS)) u_up_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bit_en  (rx_bit_en),
    .bit_in  (rx_bit),
    .code    ({up_lo_q, up_hi_q}),
    .len_sel (len_q.up_len),
    .present (up_present)
  );

  repeat_code_detector #(.INTEG_BITS(INTEG_BITS)) u_dn_det (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bit_en  (rx_bit_en),
    .bit_in  (rx_bit),
    .code    ({dn_lo_q, dn_hi_q}),
    .len_sel (len_q.dn_len),
    .present (dn_present)
  );

  // *****************************************************************
  // One-second timer and automatic remote loopback
  // *****************************************************************
  // Seconds are counted in received bits, so they stop with the line.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt_q  <= '0;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= rx_bit_en && sec_cnt_q == SCW'(SECOND_BITS - 1);
      if (rx_bit_en) begin
        sec_cnt_q <= (sec_cnt_q == SCW'(SECOND_BITS - 1)) ? '0
                     : sec_cnt_q + 1'b1;
      end
    end
  end

  // A second counts only if the code never dropped during it.
  assign up_ok = !up_drop_q && up_present;
  assign dn_ok = !dn_drop_q && dn_present;

  always_ff @(posedge aclk) begin
    if (!aresetn || !auto_en) begin
      up_drop_q   <= 1'b1;
      dn_drop_q   <= 1'b1;
      up_secs_q   <= 3'h0;
      dn_secs_q   <= 3'h0;
      arl_state_q <= ARL_IDLE;
    end else if (sec_tick_q) begin
      up_drop_q <= !up_present;
      dn_drop_q <= !dn_present;
      up_secs_q <= (up_ok && up_secs_q < HOLD_SECONDS) ? up_secs_q + 3'h1
                   : (up_ok ? up_secs_q : 3'h0);
      dn_secs_q <= (dn_ok && dn_secs_q < HOLD_SECONDS) ? dn_secs_q + 3'h1
                   : (dn_ok ? dn_secs_q : 3'h0);
      case (arl_state_q)
        ARL_IDLE: begin
          if (up_ok && up_secs_q == HOLD_SECONDS - 3'h1) begin
            arl_state_q <= ARL_ACTIVE;
          end
        end
        ARL_ACTIVE: begin
          if (dn_ok && dn_secs_q == HOLD_SECONDS - 3'h1) begin
            arl_state_q <= ARL_IDLE;
          end
        end
        default: arl_state_q <= ARL_IDLE;
      endcase
    end else begin
      if (!up_present) begin
        up_drop_q <= 1'b1;
      end
      if (!dn_present) begin
        dn_drop_q <= 1'b1;
      end
    end
  end

  // *****************************************************************
  // Checks
  // *****************************************************************
  property p_auto_off;
    @(posedge aclk) disable iff (!aresetn)
    !auto_en |=> arl_state_q == ARL_IDLE;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("Auto loopback active while disabled.");

  property p_arl_up;
    @(posedge aclk) disable iff (!aresetn)
    (auto_en && sec_tick_q && arl_state_q == ARL_IDLE && up_ok
     && up_secs_q == 3'h4) |=> remote_loopback;
  endproperty
  a_arl_up: assert property (p_arl_up)
    else $error("Fifth up second did not enter loopback.");

  property p_arl_down;
    @(posedge aclk) disable iff (!aresetn)
    (auto_en && sec_tick_q && arl_state_q == ARL_ACTIVE && dn_ok
     && dn_secs_q == 3'h4) |=> !remote_loopback;
  endproperty
  a_arl_down: assert property (p_arl_down)
    else $error("Fifth down second did not leave loopback.");

  property p_arl_hold;
    @(posedge aclk) disable iff (!aresetn)
    (remote_loopback && !sec_tick_q && auto_en) |=> remote_loopback;
  endproperty
  a_arl_hold: assert property (p_arl_hold)
    else $error("Loopback left between second ticks.");

  property p_sec_set;
    @(posedge aclk) disable iff (!aresetn)
    sec_tick_q |=> sec_flag_q;
  endproperty
  a_sec_set: assert property (p_sec_set)
    else $error("Second tick lost.");

  property p_sec_clear;
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && rd_idx == IDX_RX_INFO && !sec_tick_q) |=> !sec_flag_q;
  endproperty
  a_sec_clear: assert property (p_sec_clear)
    else $error("Info read did not clear second flag.");

  property p_info_read;
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && rd_idx == IDX_RX_INFO)
      |=> rdata[7:4] == $past(level_s) && rdata[3:2] == 2'h0 && rvalid;
  endproperty
  a_info_read: assert property (p_info_read)
    else $error("Info read level field wrong.");

  property p_tx_idle;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit_en && !tx_en) |=> tx_line_data == $past(tx_data_s);
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("Normal data not passed when code disabled.");

  property p_tx_code;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit_en && tx_en && tx_phase_q == 4'h0)
      |=> tx_line_data == $past(tx_lo_q[7]);
  endproperty
  a_tx_code: assert property (p_tx_code)
    else $error("Pattern did not start with low byte bit 7.");

  property p_tx_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit_en && tx_en && tx_phase_q == tx_last
     && $stable(len_q)) |=> tx_phase_q == 4'h0;
  endproperty
  a_tx_wrap: assert property (p_tx_wrap)
    else $error("Transmit phase did not wrap at length.");

  property p_up_latch;
    @(posedge aclk) disable iff (!aresetn)
    up_present |=> up_flag_q;
  endproperty
  a_up_latch: assert property (p_up_latch)
    else $error("Loop-up status not latched.");

  c_arl: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(remote_loopback));
  c_up_seen: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(up_flag_q));
  c_sec_read: cover property (@(posedge aclk) disable iff (!aresetn)
    sec_flag_q && rd_take && rd_idx == IDX_RX_INFO);
endmodule

/* File: hw/lcu_pkg.sv */
// Shared constants and types for the in-band loop-code unit.
package lcu_pkg;
  // Receive bit rate and the times that are counted in received bits.
  localparam int RX_BIT_RATE_HZ   = 2048000;
  localparam int T_INTEG_MS       = 48;
  localparam int T_SECOND_S       = 1;
  localparam int INTEG_BITS_DFLT  = T_INTEG_MS * (RX_BIT_RATE_HZ / 1000);
  localparam int SECOND_BITS_DFLT = T_SECOND_S * RX_BIT_RATE_HZ;
  localparam logic [2:0] HOLD_SECONDS = 3'h5;
  // Error budget is one bit in two to the ERR_SHIFT of the window.
  localparam int ERR_SHIFT = 4;
  localparam int ICW       = 17;
  localparam int SCW       = 21;
  // Register indexes; the byte address is four times the index.
  localparam logic [5:0] IDX_RX_INFO  = 6'h09;
  localparam logic [5:0] IDX_LEN_CTRL = 6'h0A;
  localparam logic [5:0] IDX_TX_LO    = 6'h0B;
  localparam logic [5:0] IDX_TX_HI    = 6'h0C;
  localparam logic [5:0] IDX_UP_LO    = 6'h0D;
  localparam logic [5:0] IDX_UP_HI    = 6'h0E;
  localparam logic [5:0] IDX_DN_LO    = 6'h0F;
  localparam logic [5:0] IDX_DN_HI    = 6'h10;
  localparam logic [5:0] IDX_CTRL     = 6'h20;
  localparam logic [5:0] IDX_STATUS   = 6'h21;
  // Field positions.
  localparam int INFO_LVL_LSB = 4;
  localparam int INFO_ARL_BIT = 1;
  localparam int INFO_SEC_BIT = 0;
  localparam int CTRL_TXE_BIT = 0;
  localparam int CTRL_ARE_BIT = 1;
  localparam int ST_UP_BIT    = 7;
  localparam int ST_DN_BIT    = 6;
  // Reset values.
  localparam logic [7:0] LEN_CTRL_RST = 8'h00;
  localparam logic [7:0] PATTERN_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  // Length selects and the last pattern phase they map to.
  localparam logic [1:0] TX_LEN_5  = 2'h0;
  localparam logic [1:0] TX_LEN_6  = 2'h1;
  localparam logic [1:0] TX_LEN_7  = 2'h2;
  localparam logic [2:0] RX_LEN_16 = 3'h7;
  localparam logic [3:0] LAST_16   = 4'hF;
  localparam logic [3:0] LAST_5    = 4'h4;
  localparam logic [3:0] LAST_6    = 4'h5;
  localparam logic [3:0] LAST_7    = 4'h6;
  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Length control register layout.
  typedef struct packed {
    logic [1:0] tx_len;
    logic [2:0] up_len;
    logic [2:0] dn_len;
  } len_ctrl_s;
  typedef enum logic {ARL_IDLE = 1'b0, ARL_ACTIVE = 1'b1} arl_state_e;
endpackage

/* File: hw/repeat_code_detector.sv */
// Error-tolerant detector for one repeating code of 1 to 8 or 16 bits.
`timescale 1ns/1ps
module repeat_code_detector
  import lcu_pkg::*;
#(
  parameter int INTEG_BITS = INTEG_BITS_DFLT
) (
  // Clock and reset.
  input  logic        aclk,
  input  logic        aresetn,
  // Received bit stream.
  input  logic        bit_en,
  input  logic        bit_in,
  // Code and its length select.
  input  logic [15:0] code,
  input  logic [2:0]  len_sel,
  // Code seen in the last window.
  output logic        present
);
  logic [3:0]     phase_q;
  logic [ICW-1:0] bit_cnt_q;
  logic [ICW-1:0] err_cnt_q;
  logic           present_q;
  logic [3:0]     last;
  logic           miss;
  logic [ICW-1:0] err_next;

  // Lengths 1 to 7 use the top bits; all-ones compares the whole word.
  assign last     = (len_sel == RX_LEN_16) ? LAST_16 : {1'b0, len_sel};
  assign miss     = bit_in ^ code[4'hF - phase_q];
  assign err_next = err_cnt_q + {{(ICW-1){1'b0}}, miss};
  assign present  = present_q;

  // Too many misses slips the phase by one bit, so a wrong alignment
  // is dropped within a few thousand bits instead of a whole window.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q   <= 4'h0;
      bit_cnt_q <= '0;
      err_cnt_q <= '0;
      present_q <= 1'b0;
    end else if (bit_en) begin
      if (err_next > ICW'(INTEG_BITS >> ERR_SHIFT)) begin
        bit_cnt_q <= '0;
        err_cnt_q <= '0;
        present_q <= 1'b0;
      end else begin
        phase_q   <= (phase_q >= last) ? 4'h0 : phase_q + 4'h1;
        err_cnt_q <= err_next;
        if (bit_cnt_q == ICW'(INTEG_BITS - 1)) begin
          bit_cnt_q <= '0;
          err_cnt_q <= '0;
          present_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 1'b1;
        end
      end
    end
  end

  // *****************************************************************
  // Checks
  // *****************************************************************
  property p_window_detect;
    @(posedge aclk) disable iff (!aresetn)
    (bit_en && bit_cnt_q == ICW'(INTEG_BITS - 1)
     && err_next <= ICW'(INTEG_BITS >> ERR_SHIFT)) |=> present_q;
  endproperty
  a_window_detect: assert property (p_window_detect)
    else $error("Clean window did not raise present.");

  property p_slip_drops;
    @(posedge aclk) disable iff (!aresetn)
    (bit_en && err_next > ICW'(INTEG_BITS >> ERR_SHIFT))
      |=> !present_q && phase_q == $past(phase_q) && err_cnt_q == '0;
  endproperty
  a_slip_drops: assert property (p_slip_drops)
    else $error("Error overflow did not slip and drop.");
endmodule

/* File: verif/line_partner.sv */
// Far-end line terminal model: repeating code source and both bit clocks.
`timescale 1ns/1ps
module line_partner (
  // Clock.
  input  wire logic        aclk,
  // Code to send and its length.
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  plen,
  // Line pins.
  output logic             rx_clk_pin = 1'b0,
  output logic             rx_data_pin = 1'b0,
  output logic             tx_clk_pin = 1'b0
);
  logic [2:0] ph = 3'h0;
  int         bitn = 0;
  int         cnt = 0;
  // Eight clocks a bit; each hundredth bit is flipped, the worst line allowed.
  always @(posedge aclk) begin
    ph <= ph + 3'h1;
    rx_clk_pin <= ph[2];
    tx_clk_pin <= ~ph[2];
    if (ph == 3'h7) begin
      rx_data_pin <= pat[15 - bitn] ^ (cnt % 100 == 99);
      bitn <= (bitn + 1) % plen;
      cnt <= cnt + 1;
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the loop-code unit.
`timescale 1ns/1ps
module tb_top import lcu_pkg::*; ;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, tx_data_pin = 0, awready, wready, bvalid;
  logic        arready, rvalid, rx_clk_pin, rx_data_pin, tx_clk_pin;
  logic        tx_line_data, remote_loopback;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hF, rx_level_pin = 4'h0;
  logic [4:0]  plen = 5'h5;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, lo, hi;
  logic [15:0] pat = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, bv, m;
  int          error_cnt = 0, samples_checked = 0, seed = 32'hB6BAC71A, n;
  inband_loop_code_unit #(.INTEG_BITS(64), .SECOND_BITS(200)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin),
    .tx_clk_pin(tx_clk_pin), .tx_data_pin(tx_data_pin), .rx_level_pin(rx_level_pin),
    .tx_line_data(tx_line_data), .remote_loopback(remote_loopback));
  line_partner u_far (.aclk(aclk), .pat(pat), .plen(plen), .rx_clk_pin(rx_clk_pin),
    .rx_data_pin(rx_data_pin), .tx_clk_pin(tx_clk_pin));
  // Free-running 50 MHz clock.
  always #10 aclk = ~aclk;
  // Count a compare and report a mismatch.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Ones in the first p code bits; any rotation of the code keeps this count.
  function automatic int code_ones(input logic [15:0] c, input int p);
    return $countones(c >> (16 - p));
  endfunction
  // Verdict and end of run.
  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A bounded wait that ran dry counts as a mismatch and ends the run.
  task automatic tmo();
    if (n > 8) begin
      chk("wait", 0, n);
      summarize();
    end
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 9);
    bready <= 1'b0;
    chk("bresp", RESP_OKAY, bresp);
    tmo();
  endtask
  // Read with a masked compare of the data and of the answer code.
  task automatic rchk(input string s, input logic [5:0] idx, input logic [31:0] k,
                      input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 9);
    rready <= 1'b0;
    chk(s, e, rdata & k);
    chk("rresp", er, rresp);
    tmo();
  endtask
  // Random code; bit phase is unknown, so check period and ones count.
  task automatic txchk(input logic [1:0] sel, input int p);
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    wr(IDX_TX_LO, lo);
    wr(IDX_TX_HI, hi);
    wr(IDX_LEN_CTRL, {sel, 6'h0});
    wr(IDX_CTRL, 8'h01);
    for (n = 0; n < 9 && tx_clk_pin; n++) @(posedge aclk);
    for (n = 0; n < 9 && !tx_clk_pin; n++) @(posedge aclk);
    tmo();
    repeat (6) @(posedge aclk);
    for (int i = 0; i < 2 * p; i++) begin
      bv = {bv[30:0], tx_line_data};
      repeat (8) @(posedge aclk);
    end
    m = (32'h1 << p) - 32'h1;
    chk("tx period", 0, (bv ^ (bv >> p)) & m);
    chk("tx ones", code_ones({lo, hi}, p), $countones(bv & m));
    wr(IDX_CTRL, 8'h00);
    tx_data_pin <= p[0];
    repeat (40) @(posedge aclk);
    chk("tx data", p[0], tx_line_data);
  endtask
  // Main sequence: registers, transmit codes, detection, auto loopback.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("len rst", IDX_LEN_CTRL, 32'hFF, 32'h0);
    rchk("unmapped", 6'h3F, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    lo = 8'($random(seed));
    wr(IDX_LEN_CTRL, lo);
    rchk("len", IDX_LEN_CTRL, 32'hFFFFFFFF, {24'h0, lo});
    wstrb <= 4'h0;
    wr(IDX_LEN_CTRL, ~lo);
    wstrb <= 4'hF;
    rchk("len kept", IDX_LEN_CTRL, 32'hFF, {24'h0, lo});
    rx_level_pin <= 4'($random(seed));
    repeat (5) @(posedge aclk);
    rchk("level", IDX_RX_INFO, 32'hF0, {24'h0, rx_level_pin, 4'h0});
    for (int k = 0; k < 4; k++) txchk(2'(k), k == 3 ? 16 : k + 5);
    wr(IDX_UP_LO, 8'h80);
    wr(IDX_DN_LO, 8'hF0);
    wr(IDX_DN_HI, 8'hF0);
    wr(IDX_LEN_CTRL, 8'h27);
    wr(IDX_CTRL, 8'h02);
    pat <= 16'h8000;
    repeat (3200) @(posedge aclk);
    rchk("clr", IDX_STATUS, 32'hC0, 32'hC0);
    rchk("up", IDX_STATUS, 32'hC0, 32'h80);
    repeat (11200) @(posedge aclk);
    chk("arl", 1, remote_loopback);
    rchk("arl sec", IDX_RX_INFO, 32'h3, 32'h3);
    rchk("sec clr", IDX_RX_INFO, 32'h1, 32'h0);
    pat <= 16'hF0F0;
    plen <= 5'h10;
    repeat (4800) @(posedge aclk);
    chk("arl held", 1, remote_loopback);
    repeat (6400) @(posedge aclk);
    chk("arl off", 0, remote_loopback);
    rchk("clr", IDX_STATUS, 32'hC0, 32'hC0);
    rchk("dn", IDX_STATUS, 32'hC0, 32'h40);
    pat <= 16'h8000;
    plen <= 5'h5;
    repeat (11200) @(posedge aclk);
    chk("arl", 1, remote_loopback);
    wr(IDX_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("arl dis", 0, remote_loopback);
    summarize();
  end
endmodule
